// ==== rtl/atpc_pkg.sv ====
// Purpose: Shared constants and types for the converter trigger and pacing block.
// Assumes: One 10 MHz core clock.
// Notes: Counts and reset values live here.
`default_nettype none
package atpc_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int ATPC_CLK_NS = 100;
    localparam int ATPC_CONV_NS = 10000;
    localparam int ATPC_CONV_CYCLES = (ATPC_CONV_NS + ATPC_CLK_NS - 1) / ATPC_CLK_NS;
    localparam int ATPC_WAIT_CYCLES = 2;
    localparam int ATPC_FIFO_DEPTH = 16;
    localparam int ATPC_DATA_W = 16;
    localparam int ATPC_CNT_W = 16;
    localparam int ATPC_MAX_SCAN = 16;
    localparam logic [ATPC_CNT_W-1:0] ATPC_DIV_RESET = 16'h0002;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        ATPC_TRIG_EDGE_POS,
        ATPC_TRIG_EDGE_NEG,
        ATPC_TRIG_LEVEL_POS,
        ATPC_TRIG_LEVEL_NEG
    } atpc_trig_t;
    typedef enum logic [1:0] {
        ATPC_XFER_SINGLE,
        ATPC_XFER_SYNC,
        ATPC_XFER_IRQ,
        ATPC_XFER_DMA
    } atpc_xfer_t;
endpackage
`default_nettype wire

// ==== rtl/atpc_sync.sv ====
// Purpose: Two-flop synchroniser for one external level.
// Assumes: Input may change at any time.
// Notes: The first flop is read only by the second.
`default_nettype none
module atpc_sync (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Level
    input wire logic async_in,
    output logic sync_out
);
    logic meta;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b1;
            sync_out <= 1'b1;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/atpc_fifo.sv ====
// Purpose: Sample FIFO between the converter and the host transfer logic.
// Assumes: Single clock, valid and ready on both sides.
// Notes: Depth must be a power of two.
`default_nettype none
module atpc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Status
    output logic empty,
    output logic full
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic do_wr;
    logic do_rd;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("FIFO depth must be a power of two of at least 2.");
    end

    assign empty = (wr_ptr == rd_ptr);
    assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign do_wr = in_valid && !full;
    assign do_rd = out_ready && !empty;

    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/atpc_top.sv ====
// Purpose: Starts and paces conversions and hands samples to the host.
// Assumes: All pins synchronous to core_clk except the external inputs, which are synchronised.
// Notes: The free counter is kept outside; the wait-state switch is a plain port.
// Functional notes
// - Software selects the active polarity of the external trigger.
// - Internal trigger starts the run immediately on enable; conversions then follow the pacer.
// - Positive-edge mode starts on a rising trigger edge.
// - Negative-edge mode starts on a falling trigger edge.
// - Positive-level mode starts while the trigger is high.
// - Negative-level mode starts while the trigger is low.
// - Single mode takes exactly one sample and reports busy until done.
// - Synchronous mode takes a counted run and reports busy until done.
// - Interrupt mode raises a selectable host interrupt when data is ready.
// - DMA mode issues requests on channel 1 or 3, held while data waits until acknowledged.
// - Pacer is counters 1 and 2 chained, one clocking the other.
// - Counter 0 stays free for user functions.
// - With gating on, pacer pulses pass only while the gate line is high; others are dropped.
// - External pacer clock line is not a general input then.
// - Trigger and counter-0 gate lines are dedicated when the external trigger is used.
// - With analog input off, the pacer raises interrupts for other I/O.
// - A switch inserts wait states on 8-bit host cycles.
// - Paced mode does one conversion per pacer pulse.
// - Burst mode scans one to sixteen channels per pacer pulse.
`default_nettype none
module atpc_top
    import atpc_pkg::*;
#(
    parameter int DATA_W = atpc_pkg::ATPC_DATA_W,
    parameter int FIFO_DEPTH = atpc_pkg::ATPC_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // External pins
    input wire logic [3:0] general_digital_inputs,
    output logic [3:0] general_digital_inputs_read,
    // Control
    input wire logic ai_enable,
    input wire logic trig_external,
    input wire atpc_pkg::atpc_trig_t trig_type,
    input wire logic trig_invert,
    input wire atpc_pkg::atpc_xfer_t xfer_mode,
    input wire logic [15:0] sample_count,
    input wire logic burst_mode,
    input wire logic [3:0] burst_last_chan,
    input wire logic [15:0] burst_div,
    input wire logic pacer_external,
    input wire logic gate_enable,
    input wire logic [15:0] pacer_div1,
    input wire logic [15:0] pacer_div2,
    input wire logic irq_sel,
    input wire logic dma_chan3,
    input wire logic wait_enable,
    // Host bus cycle
    input wire logic bus_cycle_8bit,
    output logic bus_wait,
    // Converter
    output logic conv_start,
    output logic [3:0] conv_chan,
    input wire logic conv_done,
    input wire logic [DATA_W-1:0] conv_data,
    // Host side
    output logic busy,
    output logic triggered,
    output logic [1:0] irq_lines,
    output logic dma_req1,
    output logic dma_req3,
    input wire logic dma_ack,
    input wire logic host_read,
    output logic [DATA_W-1:0] host_data,
    output logic host_data_valid,
    output logic overrun,
    output logic pacer_tick
);
    import atpc_pkg::*;

    if (DATA_W < 1 || FIFO_DEPTH < 2) begin : g_bad_cfg
        $error("Unsupported width or depth.");
    end

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [3:0] din_s;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            atpc_sync u_sync (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .async_in(general_digital_inputs[gi]),
                .sync_out(din_s[gi])
            );
        end
    endgenerate
    logic pacer_clock_gate_input;
    logic external_trigger_input;
    logic counter_zero_gate_input;
    assign pacer_clock_gate_input = din_s[0];
    assign external_trigger_input = din_s[1];
    assign counter_zero_gate_input = din_s[2];
    // Dedicated lines read as high, the idle pull-up level, when claimed.
    assign general_digital_inputs_read = {din_s[3],
        counter_zero_gate_input | trig_external,
        external_trigger_input | trig_external,
        pacer_clock_gate_input | pacer_external | gate_enable};

    logic trig_d;
    logic pclk_d;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_d <= 1'b1;
            pclk_d <= 1'b1;
        end else begin
            trig_d <= external_trigger_input;
            pclk_d <= pacer_clock_gate_input;
        end
    end

    // ----------------------------------------
    // Pacer: two chained dividers
    // ----------------------------------------
    // Counter 0 is not built here; it stays with the user timer outside.
    logic [15:0] cnt1;
    logic [15:0] cnt2;
    logic out1;
    logic int_tick;
    assign out1 = (cnt1 == 16'h0001);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt1 <= ATPC_DIV_RESET;
            cnt2 <= ATPC_DIV_RESET;
            int_tick <= 1'b0;
        end else begin
            int_tick <= 1'b0;
            cnt1 <= out1 ? pacer_div1 : cnt1 - 16'h0001;
            if (out1) begin
                if (cnt2 <= 16'h0001) begin
                    cnt2 <= pacer_div2;
                    int_tick <= 1'b1;
                end else begin
                    cnt2 <= cnt2 - 16'h0001;
                end
            end
        end
    end
    logic ext_tick;
    logic raw_tick;
    assign ext_tick = pacer_clock_gate_input && !pclk_d;
    assign raw_tick = pacer_external ? ext_tick : int_tick;
    assign pacer_tick = raw_tick && (!gate_enable || pacer_clock_gate_input);

    // ----------------------------------------
    // Trigger detection
    // ----------------------------------------
    logic trig_now;
    logic tv;
    logic tv_d;
    assign tv = external_trigger_input ^ trig_invert;
    assign tv_d = trig_d ^ trig_invert;
    always_comb begin
        case (trig_type)
            ATPC_TRIG_EDGE_POS: trig_now = tv && !tv_d;
            ATPC_TRIG_EDGE_NEG: trig_now = !tv && tv_d;
            ATPC_TRIG_LEVEL_POS: trig_now = tv;
            default: trig_now = !tv;
        endcase
    end

    // ----------------------------------------
    // Acquisition control
    // ----------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN, ST_DONE} atpc_state_t;
    atpc_state_t state;
    logic [15:0] left;
    logic [3:0] chan;
    logic [15:0] bcnt;
    logic scanning;
    logic conv_busy;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_empty;
    logic start_ok;
    logic burst_tick;
    assign burst_tick = (bcnt == 16'h0001);
    assign start_ok = !conv_busy && fifo_in_ready && (state == ST_RUN) && (left != 16'h0000)
        && (burst_mode ? (scanning && burst_tick) : pacer_tick);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            triggered <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: if (ai_enable) state <= ST_ARMED;
                ST_ARMED: begin
                    if (!ai_enable) begin
                        state <= ST_IDLE;
                    end else if (!trig_external || trig_now) begin
                        state <= ST_RUN;
                        triggered <= 1'b1;
                    end
                end
                ST_RUN: begin
                    if (!ai_enable) begin
                        state <= ST_IDLE;
                        triggered <= 1'b0;
                    end else if (left == 16'h0000 && !conv_busy) begin
                        state <= ST_DONE;
                    end
                end
                default: if (!ai_enable) begin
                    state <= ST_IDLE;
                    triggered <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            left <= 16'h0000;
            chan <= 4'h0;
            scanning <= 1'b0;
            bcnt <= 16'h0001;
            conv_start <= 1'b0;
            conv_busy <= 1'b0;
        end else begin
            conv_start <= start_ok;
            if (state == ST_ARMED) begin
                left <= (xfer_mode == ATPC_XFER_SINGLE) ? 16'h0001 : sample_count;
                chan <= 4'h0;
                scanning <= 1'b0;
            end
            if (burst_mode && pacer_tick && !scanning && state == ST_RUN) begin
                scanning <= 1'b1;
                chan <= 4'h0;
            end
            bcnt <= (burst_tick || !scanning) ? burst_div : bcnt - 16'h0001;
            if (start_ok) begin
                conv_busy <= 1'b1;
                left <= left - 16'h0001;
            end else if (conv_done) begin
                conv_busy <= 1'b0;
                if (burst_mode && chan == burst_last_chan) begin
                    scanning <= 1'b0;
                    chan <= 4'h0;
                end else begin
                    chan <= chan + 4'h1;
                end
            end
        end
    end
    assign conv_chan = chan;
    assign busy = (state == ST_RUN) || (state == ST_ARMED);

    // ----------------------------------------
    // Sample buffer and host transfer
    // ----------------------------------------
    logic drain;
    logic dma_pend;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            overrun <= 1'b0;
        end else if (conv_done && !fifo_in_ready) begin
            overrun <= 1'b1;
        end else if (!ai_enable) begin
            overrun <= 1'b0;
        end
    end
    assign drain = (xfer_mode == ATPC_XFER_DMA) ? (dma_ack && fifo_out_valid) : host_read;

    atpc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(conv_done),
        .in_ready(fifo_in_ready),
        .in_data(conv_data),
        .out_valid(fifo_out_valid),
        .out_ready(drain),
        .out_data(host_data),
        .empty(fifo_empty),
        .full()
    );
    assign host_data_valid = fifo_out_valid;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_lines <= 2'b00;
            dma_pend <= 1'b0;
        end else begin
            // Level interrupt: holds while data waits, or pulses per pacer tick when idle.
            irq_lines <= 2'b00;
            if ((xfer_mode == ATPC_XFER_IRQ && !fifo_empty) || (!ai_enable && int_tick)) begin
                irq_lines[irq_sel] <= 1'b1;
            end
            dma_pend <= (xfer_mode == ATPC_XFER_DMA) && !fifo_empty && !dma_ack;
        end
    end
    // One request per word; dropped for the cycle after the acknowledge.
    assign dma_req1 = dma_pend && !dma_chan3;
    assign dma_req3 = dma_pend && dma_chan3;

    // ----------------------------------------
    // Wait states
    // ----------------------------------------
    logic [1:0] wcnt;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wcnt <= 2'b00;
        end else if (bus_cycle_8bit && wait_enable && wcnt == 2'b00) begin
            wcnt <= 2'(ATPC_WAIT_CYCLES);
        end else if (wcnt != 2'b00) begin
            wcnt <= wcnt - 2'b01;
        end
    end
    assign bus_wait = (wcnt > 2'b01);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_trig_seen;
        state == ST_ARMED && trig_external && trig_now && ai_enable;
    endsequence
    property p_trig_run;
        @(posedge core_clk) disable iff (!rst_n) s_trig_seen |=> state == ST_RUN;
    endproperty
    a_trig_run: assert property (p_trig_run) else $error("Trigger did not start run.");
    property p_internal;
        @(posedge core_clk) disable iff (!rst_n)
            state == ST_ARMED && ai_enable && !trig_external |=> triggered;
    endproperty
    a_internal: assert property (p_internal) else $error("Internal start missed.");
    property p_gate;
        @(posedge core_clk) disable iff (!rst_n)
            gate_enable && !pacer_clock_gate_input |-> !pacer_tick;
    endproperty
    a_gate: assert property (p_gate) else $error("Pacer passed closed gate.");
    property p_single;
        @(posedge core_clk) disable iff (!rst_n)
            xfer_mode == ATPC_XFER_SINGLE && conv_start |-> left == 16'h0000;
    endproperty
    a_single: assert property (p_single) else $error("Single mode took extra.");
    property p_dma;
        @(posedge core_clk) disable iff (!rst_n) !(dma_req1 && dma_req3);
    endproperty
    a_dma: assert property (p_dma) else $error("Both DMA channels requested.");
    property p_rearm;
        @(posedge core_clk) disable iff (!rst_n)
            state == ST_RUN && ai_enable |=> state != ST_ARMED;
    endproperty
    a_rearm: assert property (p_rearm) else $error("Re-armed without disable.");
    property p_irq;
        @(posedge core_clk) disable iff (!rst_n)
            xfer_mode == ATPC_XFER_IRQ && !fifo_empty |=> irq_lines[irq_sel];
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt not raised.");
    property p_wait;
        @(posedge core_clk) disable iff (!rst_n)
            bus_cycle_8bit && wait_enable && wcnt == 2'b00 |=> bus_wait ##1 !bus_wait;
    endproperty
    a_wait: assert property (p_wait) else $error("Wait state length wrong.");
endmodule
`default_nettype wire

// ==== testbench/atpc_conv_model.sv ====
// Purpose: Converter model that answers each start pulse given while idle with one word.
// Assumes: Start pulses come from the block under test only.
// Notes: Data lines toggle between answers so a stale word never matches.
`default_nettype none
module atpc_conv_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control
    input wire logic slow,
    input wire logic conv_start,
    // Answer
    output logic conv_done,
    output logic [15:0] conv_data,
    output logic overlap
);
    timeunit 1ns;
    timeprecision 1ns;
    int left;
    logic [15:0] seq;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            left <= 0;
            seq <= 16'h0000;
            conv_done <= 1'b0;
            conv_data <= 16'h0000;
            overlap <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            conv_data <= ~conv_data;
            if (conv_start) begin
                // A start while busy would lose a word, so it is flagged.
                overlap <= overlap | (left != 0);
                left <= slow ? 20 : 2;
            end else if (left == 1) begin
                conv_done <= 1'b1;
                conv_data <= 16'h5a00 + seq;
                seq <= seq + 16'h0001;
                left <= 0;
            end else if (left != 0) begin
                left <= left - 1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/test_adc_trigger_pacing_control.sv ====
// Purpose: Self-checking bench for the trigger and pacing block.
// Assumes: Pacer loads of 3 and 2 give a tick every 6 cycles.
// Notes: Inputs change 10 ns after each rising edge.
`default_nettype none
module test_adc_trigger_pacing_control;
    timeunit 1ns;
    timeprecision 1ns;
    import atpc_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic rst_n, ai_enable, trig_external, trig_invert, burst_mode, pacer_external;
    logic gate_enable, irq_sel, dma_chan3, wait_enable, bus_cycle_8bit, dma_ack;
    logic host_read, slow;
    logic [3:0] general_digital_inputs, burst_last_chan;
    logic [15:0] sample_count, burst_div, pacer_div1, pacer_div2;
    atpc_trig_t trig_type;
    atpc_xfer_t xfer_mode;
    wire logic [3:0] general_digital_inputs_read, conv_chan;
    wire logic bus_wait, conv_start, conv_done, busy, triggered, dma_req1, dma_req3;
    wire logic host_data_valid, overrun, pacer_tick, overlap;
    wire logic [1:0] irq_lines;
    wire logic [15:0] conv_data, host_data;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int exp_seq = 0;
    always #50 core_clk = ~core_clk;
    atpc_top uut (.core_clk, .rst_n, .general_digital_inputs, .general_digital_inputs_read,
        .ai_enable, .trig_external, .trig_type, .trig_invert, .xfer_mode, .sample_count,
        .burst_mode, .burst_last_chan, .burst_div, .pacer_external, .gate_enable,
        .pacer_div1, .pacer_div2, .irq_sel, .dma_chan3, .wait_enable, .bus_cycle_8bit,
        .bus_wait, .conv_start, .conv_chan, .conv_done, .conv_data, .busy, .triggered,
        .irq_lines, .dma_req1, .dma_req3, .dma_ack, .host_read, .host_data,
        .host_data_valid, .overrun, .pacer_tick);
    atpc_conv_model conv (.core_clk, .rst_n, .slow, .conv_start, .conv_done, .conv_data,
        .overlap);
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #10;
    endtask
    task automatic chk_bit(input string what, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("FAIL %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic chk_word(input string what, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask
    // Bounded wait; a pulse already present on entry is not counted.
    task automatic wait_sig(input int sel, input int lim, output logic seen);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            step(1);
            case (sel)
                0: seen = (host_data_valid === 1'b1);
                1: seen = (triggered === 1'b1);
                2: seen = (conv_start === 1'b1);
                3: seen = (pacer_tick === 1'b1);
                default: seen = (busy === 1'b0);
            endcase
        end
    endtask
    task automatic pop(input logic via_dma);
        logic seen;
        wait_sig(0, 400, seen);
        chk_bit("word ready", 1'b1, seen);
        chk_word("host data", 16'h5a00 + exp_seq[15:0], host_data);
        exp_seq++;
        if (via_dma) dma_ack = 1'b1;
        else host_read = 1'b1;
        step(1);
        dma_ack = 1'b0;
        host_read = 1'b0;
    endtask
    task automatic arm(input logic ext, input atpc_trig_t t, input logic inv,
        input atpc_xfer_t m, input logic [15:0] n);
        trig_external = ext;
        trig_type = t;
        trig_invert = inv;
        xfer_mode = m;
        sample_count = n;
        ai_enable = 1'b1;
    endtask
    task automatic done_check();
        logic seen;
        wait_sig(4, 400, seen);
        chk_bit("busy cleared", 1'b1, seen);
        ai_enable = 1'b0;
        step(3);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // A hang counts as a mismatch and still reaches the report.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 30000) begin
            errors++;
            $display("FAIL run time expected finished seen running");
            wrap_up();
        end
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        logic seen;
        rst_n = 1'b0;
        general_digital_inputs = 4'hf;
        {ai_enable, trig_external, trig_invert, burst_mode, pacer_external} = 5'h00;
        {gate_enable, irq_sel, dma_chan3, wait_enable, bus_cycle_8bit} = 5'h00;
        {dma_ack, host_read, slow} = 3'h0;
        trig_type = ATPC_TRIG_EDGE_POS;
        xfer_mode = ATPC_XFER_SINGLE;
        sample_count = 16'h0001;
        burst_last_chan = 4'h0;
        burst_div = 16'h0002;
        pacer_div1 = 16'h0003;
        pacer_div2 = 16'h0002;
        step(10);
        rst_n = 1'b1;
        step(1);
        chk_word("reset state", 16'h000f, {busy, triggered, irq_lines, dma_req1, dma_req3,
            host_data_valid, overrun, 4'h0, general_digital_inputs_read});
        for (int w = 0; w < 2; w++) begin
            wait_enable = w[0];
            bus_cycle_8bit = 1'b1;
            step(1);
            bus_cycle_8bit = 1'b0;
            chk_bit("bus wait", w[0], bus_wait);
            step(1);
            chk_bit("bus wait end", 1'b0, bus_wait);
        end
        wait_sig(3, 20, seen);
        chk_bit("idle pacer", 1'b1, seen);
        wait_sig(3, 5, seen);
        chk_bit("pacer early", 1'b0, seen);
        step(1);
        chk_bit("pacer period", 1'b1, pacer_tick);
        step(1);
        chk_word("idle irq", 16'h0001, {14'h0, irq_lines});
        arm(1'b0, ATPC_TRIG_EDGE_POS, 1'b0, ATPC_XFER_SINGLE, 16'h0005);
        wait_sig(1, 5, seen);
        chk_bit("internal start", 1'b1, seen);
        chk_bit("busy single", 1'b1, busy);
        wait_sig(2, 20, seen);
        chk_bit("paced start", 1'b1, seen);
        pop(1'b0);
        step(20);
        chk_bit("one sample only", 1'b0, host_data_valid);
        done_check();
        for (int t = 0; t < 4; t++) begin
            for (int v = 0; v < 2; v++) begin
                general_digital_inputs[1] = t[0] ^ v[0];
                step(4);
                arm(1'b1, atpc_trig_t'(t[1:0]), v[0], ATPC_XFER_SINGLE, 16'h0001);
                step(10);
                chk_bit("trigger held", 1'b0, triggered);
                chk_bit("trigger line", 1'b1, general_digital_inputs_read[1]);
                general_digital_inputs[1] = ~(t[0] ^ v[0]);
                wait_sig(1, 6, seen);
                chk_bit("trigger fired", 1'b1, seen);
                pop(1'b0);
                done_check();
            end
        end
        general_digital_inputs[0] = 1'b0;
        gate_enable = 1'b1;
        step(4);
        arm(1'b0, ATPC_TRIG_EDGE_POS, 1'b0, ATPC_XFER_SINGLE, 16'h0001);
        wait_sig(2, 40, seen);
        chk_bit("gated start", 1'b0, seen);
        general_digital_inputs[0] = 1'b1;
        wait_sig(2, 20, seen);
        chk_bit("gate open", 1'b1, seen);
        pop(1'b0);
        done_check();
        gate_enable = 1'b0;
        general_digital_inputs[0] = 1'b0;
        pacer_external = 1'b1;
        step(4);
        chk_bit("pacer line", 1'b1, general_digital_inputs_read[0]);
        arm(1'b0, ATPC_TRIG_EDGE_POS, 1'b0, ATPC_XFER_SINGLE, 16'h0001);
        wait_sig(2, 30, seen);
        chk_bit("no edge start", 1'b0, seen);
        general_digital_inputs[0] = 1'b1;
        wait_sig(2, 8, seen);
        chk_bit("edge start", 1'b1, seen);
        pop(1'b0);
        done_check();
        pacer_external = 1'b0;
        for (int c = 0; c < 2; c++) begin
            dma_chan3 = c[0];
            arm(1'b0, ATPC_TRIG_EDGE_POS, 1'b0, ATPC_XFER_DMA, 16'h0002);
            for (int k = 0; k < 2; k++) begin
                wait_sig(0, 400, seen);
                step(1);
                chk_word("dma lines", {14'h0, ~c[0], c[0]}, {14'h0, dma_req1, dma_req3});
                pop(1'b1);
            end
            step(2);
            chk_word("dma idle", 16'h0000, {14'h0, dma_req1, dma_req3});
            done_check();
        end
        for (int s = 0; s < 2; s++) begin
            irq_sel = s[0];
            arm(1'b0, ATPC_TRIG_EDGE_POS, 1'b0, ATPC_XFER_IRQ, 16'h0001);
            wait_sig(0, 400, seen);
            step(1);
            chk_word("irq lines", {14'h0, s[0], ~s[0]}, {14'h0, irq_lines});
            pop(1'b0);
            step(2);
            chk_word("irq idle", 16'h0000, {14'h0, irq_lines});
            done_check();
        end
        slow = 1'b1;
        burst_mode = 1'b1;
        burst_last_chan = 4'h3;
        arm(1'b0, ATPC_TRIG_EDGE_POS, 1'b0, ATPC_XFER_SYNC, 16'h0004);
        for (int i = 0; i < 4; i++) begin
            wait_sig(2, 100, seen);
            chk_word("scan channel", i[15:0], {12'h0, conv_chan});
        end
        for (int i = 0; i < 4; i++) pop(1'b0);
        done_check();
        slow = 1'b0;
        burst_mode = 1'b0;
        arm(1'b0, ATPC_TRIG_EDGE_POS, 1'b0, ATPC_XFER_SYNC, 16'h0012);
        step(400);
        wait_sig(2, 60, seen);
        chk_bit("held while full", 1'b0, seen);
        chk_bit("no overrun", 1'b0, overrun);
        for (int i = 0; i < 18; i++) pop(1'b0);
        step(5);
        chk_bit("drained", 1'b0, host_data_valid);
        done_check();
        chk_bit("one start per answer", 1'b0, overlap);
        wrap_up();
    end
endmodule
`default_nettype wire
